// file: rtl/flash_ctl_pkg.sv
// constants for the flash program and erase control block
package flash_ctl_pkg;
  // address map
  localparam logic [15:0] USER_LO_ADDR     = 16'hA000;
  localparam logic [15:0] USER_HI_ADDR     = 16'hFDFF;
  localparam logic [15:0] VECT_LO_ADDR     = 16'hFFD2;
  localparam logic [15:0] VECT_HI_ADDR     = 16'hFFFF;
  localparam logic [15:0] CONTROL_ADDR     = 16'hFE08;
  localparam logic [15:0] PROTECT_ADDR     = 16'hFF80;
  // protect range bases for bits 0..3
  localparam logic [15:0] PROT_BASE0       = 16'hA000;
  localparam logic [15:0] PROT_BASE1       = 16'hC000;
  localparam logic [15:0] PROT_BASE2       = 16'hE000;
  localparam logic [15:0] PROT_BASE3       = 16'hF000;
  // control register bit positions
  localparam int          PUMP_DIV_HI_BIT  = 7;
  localparam int          PUMP_DIV_LO_BIT  = 6;
  localparam int          ERASE_SIZE_HI_BIT = 5;
  localparam int          ERASE_SIZE_LO_BIT = 4;
  localparam int          HV_EN_BIT        = 3;
  localparam int          MARGIN_BIT       = 2;
  localparam int          ERASE_BIT        = 1;
  localparam int          PROGRAM_BIT      = 0;
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  // erase size codes
  localparam logic [1:0]  SIZE_FULL        = 2'h0;
  localparam logic [1:0]  SIZE_HALF        = 2'h1;
  localparam logic [1:0]  SIZE_GROUP       = 2'h2;
  localparam logic [1:0]  SIZE_ROW         = 2'h3;
  // pump divider codes
  localparam logic [1:0]  DIV_BY1          = 2'h0;
  localparam logic [1:0]  DIV_BY4          = 2'h3;
  // geometry
  localparam int          PAGE_BYTES       = 8;
  localparam int          ROW_BYTES        = 64;
  localparam int          MARGIN_STRETCH   = 8;
  localparam logic [7:0]  ERASED_BYTE      = 8'h00;
  localparam logic [7:0]  SETTLED_BYTE     = 8'hFF;
  // fields of the latched erase address
  localparam int          A_HALF_LSB       = 14;
  localparam int          A_GROUP_LSB      = 9;
  localparam int          A_ROW_LSB        = 6;
  localparam int          A_PAGE_LSB       = 3;
endpackage

// file: rtl/flash_program_erase_control.sv
// flash program, erase and margin read sequencer with array interface
`timescale 1ns/10ps
// ======================================================================
// Overview of operation
// - erased bits read 0, programmed bits read 1
// - rows of eight eight-byte pages, row erase minimum
// - program one page at 0 or 8 boundary; code latches any eight array writes, no alignment check
// - decode user array, vectors, control, protect byte
// - pump divider: 00 /1, 01 10 /2, 11 /4
// - high voltage only after proper sequence steps
// - high voltage bit drives pump and array
// - margin cannot be set while high voltage
// - program and erase never both set
// - erase size field picks erase extent
// - erase set-up write latches block address
// - program select enables page write latching
// - margin read stretches access eight cycles
// - array unreadable while high voltage set
// - unrelated bus operations tolerated between steps
// - protect read latched, protected range clears select
// - protect bits guard ranges ending at FFFF
module flash_program_erase_control
  import flash_ctl_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // cpu bus
  input  wire logic              bus_sel_i,
  input  wire logic              bus_wr_i,
  input  wire logic [ADDR_W-1:0] bus_addr_i,
  input  wire logic [7:0]        bus_wdata_i,
  output logic [7:0]             bus_rdata_o,
  output logic                   bus_ready_o,
  // array side
  input  wire logic [7:0]        array_rdata_i,
  input  wire logic [7:0]        protect_byte_i,
  output logic                   array_read_o,
  output logic                   page_latch_o,
  output logic [ADDR_W-1:0]      page_addr_o,
  output logic [7:0]             page_data_o,
  output logic [ADDR_W-1:0]      erase_addr_o,
  output logic [ADDR_W-1:0]      erase_mask_o,
  output logic                   margin_mode_o,
  // charge pump
  output logic                   pump_on_o,
  output logic                   high_voltage_o,
  output logic                   pump_clk_en_o
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PROTECT_READ, SEQ_ARMED} seq_t;

  // ====================================================================
  // address decode
  function automatic logic in_array(input logic [ADDR_W-1:0] a);
    return ((a >= USER_LO_ADDR) && (a <= USER_HI_ADDR)) ||
           ((a >= VECT_LO_ADDR) && (a <= VECT_HI_ADDR)) ||
           (a == PROTECT_ADDR);
  endfunction

  function automatic logic [ADDR_W-1:0] size_mask(input logic [1:0] sz);
    logic [ADDR_W-1:0] m;
    m = '0;
    unique case (sz)
      SIZE_FULL:  m = '0;
      SIZE_HALF:  m[A_HALF_LSB] = 1'b1;
      SIZE_GROUP: m[A_HALF_LSB:A_GROUP_LSB] = '1;
      SIZE_ROW:   m[A_HALF_LSB:A_ROW_LSB] = '1;
    endcase
    return m;
  endfunction

  // lowest protected address from the latched protect byte
  function automatic logic [ADDR_W-1:0] prot_floor(input logic [3:0] p);
    if (p[0])      return PROT_BASE0;
    else if (p[1]) return PROT_BASE1;
    else if (p[2]) return PROT_BASE2;
    else if (p[3]) return PROT_BASE3;
    else           return '1;
  endfunction

  logic              ctl_wr;
  logic              arr_wr;
  logic              arr_rd;
  logic              prot_rd;
  logic [7:0]        control_reg;
  logic [7:0]        control_next;
  logic [3:0]        protect_reg;
  logic              protect_valid_reg;
  logic [ADDR_W-1:0] erase_addr_reg;
  logic              erase_addr_valid_reg;
  logic [3:0]        page_count_reg;
  seq_t              seq_reg;
  logic [3:0]        stretch_reg;
  logic [1:0]        div_cnt_reg;
  logic [7:0]        rdata_reg;
  logic              range_protected;
  logic              hv_ok;
  logic              prog_sel;
  logic              erase_sel;
  logic              hv_on;

  assign ctl_wr    = bus_sel_i && bus_wr_i && (bus_addr_i == CONTROL_ADDR);
  assign arr_wr    = bus_sel_i && bus_wr_i && in_array(bus_addr_i);
  assign arr_rd    = bus_sel_i && !bus_wr_i && in_array(bus_addr_i);
  assign prot_rd   = arr_rd && (bus_addr_i == PROTECT_ADDR);
  assign prog_sel  = control_reg[PROGRAM_BIT];
  assign erase_sel = control_reg[ERASE_BIT];
  assign hv_on     = control_reg[HV_EN_BIT];

  // ====================================================================
  // sequence tracking: select, protect read, then writes
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      seq_reg <= SEQ_IDLE;
    else if (!(prog_sel || erase_sel))
      seq_reg <= SEQ_IDLE;
    else
    begin
      // steps advance only on their own accesses, so other traffic may interleave
      unique case (seq_reg)
        SEQ_IDLE:         if (prot_rd) seq_reg <= SEQ_PROTECT_READ;
        SEQ_PROTECT_READ: if (erase_sel && erase_addr_valid_reg) seq_reg <= SEQ_ARMED;
                          else if (prog_sel && page_count_reg == 4'(PAGE_BYTES)) seq_reg <= SEQ_ARMED;
        SEQ_ARMED:        seq_reg <= SEQ_ARMED;
      endcase
    end
  end

  // protect byte is latched on its read
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      protect_reg       <= '0;
      protect_valid_reg <= 1'b0;
    end
    else if (prot_rd)
    begin
      protect_reg       <= protect_byte_i[3:0];
      protect_valid_reg <= 1'b1;
    end
  end

  // erase address latch: any array write after the protect read
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      erase_addr_reg       <= '0;
      erase_addr_valid_reg <= 1'b0;
    end
    else if (!erase_sel)
      erase_addr_valid_reg <= 1'b0;
    else if (arr_wr && !hv_on && seq_reg == SEQ_PROTECT_READ)
    begin
      erase_addr_reg       <= bus_addr_i & size_mask(control_reg[ERASE_SIZE_HI_BIT:ERASE_SIZE_LO_BIT]);
      erase_addr_valid_reg <= 1'b1;
    end
  end

  // page write latching while program is selected
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      page_count_reg <= '0;
      page_latch_o   <= 1'b0;
      page_addr_o    <= '0;
      page_data_o    <= ERASED_BYTE;
    end
    else
    begin
      page_latch_o <= 1'b0;
      if (!prog_sel)
        page_count_reg <= '0;
      else if (arr_wr && !hv_on && seq_reg == SEQ_PROTECT_READ
               && page_count_reg < 4'(PAGE_BYTES))
      begin
        page_latch_o   <= 1'b1;
        page_addr_o    <= bus_addr_i;
        page_data_o    <= bus_wdata_i;
        page_count_reg <= page_count_reg + 4'h1;
      end
    end
  end

  // ====================================================================
  // protection check against the requested range
  always_comb
  begin
    range_protected = 1'b0;
    if (protect_valid_reg && erase_sel && erase_addr_valid_reg)
      range_protected = ((erase_addr_reg | ~size_mask(control_reg[ERASE_SIZE_HI_BIT:ERASE_SIZE_LO_BIT]))
                         >= prot_floor(protect_reg)) && (protect_reg != 4'h0);
    // an all-clear protect byte guards nothing, not even the very top page
    else if (protect_valid_reg && prog_sel && page_count_reg != 4'h0)
      range_protected = (page_addr_o >= prot_floor(protect_reg)) && (protect_reg != 4'h0);
  end

  assign hv_ok = (seq_reg == SEQ_ARMED) && !range_protected;

  // ====================================================================
  // control register
  always_comb
  begin
    control_next = control_reg;
    if (ctl_wr)
    begin
      control_next = bus_wdata_i;
      if (bus_wdata_i[PROGRAM_BIT] && bus_wdata_i[ERASE_BIT])
        control_next[ERASE_BIT] = control_reg[ERASE_BIT] && !control_reg[PROGRAM_BIT];
      if (control_next[ERASE_BIT] && control_next[PROGRAM_BIT])
        control_next[PROGRAM_BIT] = 1'b0;
      if (bus_wdata_i[HV_EN_BIT] && !hv_on && !hv_ok)
        control_next[HV_EN_BIT] = 1'b0;
      if (control_next[HV_EN_BIT] && !(control_next[PROGRAM_BIT] || control_next[ERASE_BIT]))
        control_next[HV_EN_BIT] = 1'b0;
    end
    if (range_protected)
    begin
      control_next[PROGRAM_BIT] = 1'b0;
      control_next[ERASE_BIT]   = 1'b0;
      control_next[HV_EN_BIT]   = 1'b0;
    end
    if (control_next[HV_EN_BIT])
      control_next[MARGIN_BIT] = 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      control_reg <= CONTROL_RESET;
    else
      control_reg <= control_next;
  end

  // ====================================================================
  // charge pump clock divider and high voltage
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_cnt_reg <= '0;
    else if (!hv_on)
      div_cnt_reg <= '0;
    else
      div_cnt_reg <= div_cnt_reg + 2'h1;
  end

  always_comb
  begin
    unique case (control_reg[PUMP_DIV_HI_BIT:PUMP_DIV_LO_BIT])
      DIV_BY1: pump_clk_en_o = hv_on;
      DIV_BY4: pump_clk_en_o = hv_on && (div_cnt_reg == 2'h3);
      default: pump_clk_en_o = hv_on && div_cnt_reg[0];
    endcase
  end

  assign pump_on_o      = hv_on;
  assign high_voltage_o = hv_on;
  assign margin_mode_o  = control_reg[MARGIN_BIT];
  assign erase_addr_o   = erase_addr_reg;
  assign erase_mask_o   = size_mask(control_reg[ERASE_SIZE_HI_BIT:ERASE_SIZE_LO_BIT]);

  // ====================================================================
  // read path with margin stretch; waits keep the bus in order
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      stretch_reg <= '0;
    else if (stretch_reg != 4'h0)
      stretch_reg <= stretch_reg - 4'h1;
    else if (arr_rd && control_reg[MARGIN_BIT] && !hv_on)
      stretch_reg <= 4'(MARGIN_STRETCH);
  end

  assign bus_ready_o  = !(arr_rd && control_reg[MARGIN_BIT] && !hv_on
                          && stretch_reg != 4'h1);
  assign array_read_o = arr_rd && !hv_on;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= ERASED_BYTE;
    else if (bus_sel_i && !bus_wr_i && bus_addr_i == CONTROL_ADDR)
      rdata_reg <= control_reg;
    else if (prot_rd)
      rdata_reg <= protect_byte_i;
    else if (arr_rd && hv_on)
      rdata_reg <= SETTLED_BYTE;
    else if (arr_rd)
      rdata_reg <= array_rdata_i;
    else if (bus_sel_i && !bus_wr_i)
      rdata_reg <= ERASED_BYTE;
  end
  assign bus_rdata_o = rdata_reg;

  // ====================================================================
  hv_needs_select_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hv_on |-> (prog_sel ^ erase_sel)) else $error("hv without single select");
  select_exclusive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(prog_sel && erase_sel)) else $error("program and erase both set");
  margin_blocked_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hv_on |-> !control_reg[MARGIN_BIT]) else $error("margin set under hv");
  pump_follows_hv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pump_on_o == high_voltage_o && high_voltage_o == control_reg[HV_EN_BIT])
    else $error("pump not tied to hv");
  no_read_hv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    hv_on |-> !array_read_o) else $error("array read under hv");
  stretch_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(stretch_reg == 4'(MARGIN_STRETCH)) |-> (stretch_reg != 4'h0) [*8] ##1 stretch_reg == 4'h0)
    else $error("stretch length wrong");
  hv_after_arm_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(hv_on) |-> $past(seq_reg) == SEQ_ARMED) else $error("hv set out of sequence");
  protect_clears_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    range_protected |=> !prog_sel && !erase_sel) else $error("protected range kept select");
  div4_rate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pump_clk_en_o && control_reg[PUMP_DIV_HI_BIT:PUMP_DIV_LO_BIT] == DIV_BY4 && hv_on)
    |=> !pump_clk_en_o [*3]) else $error("divide by four wrong");
  reset_zero_a: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> control_reg == CONTROL_RESET) else $error("control not cleared");
  // the cpu holds a stalled read, so ready stays low until the last stretch cycle
  margin_ready_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(stretch_reg == 4'(MARGIN_STRETCH)) |-> !bus_ready_o [*7] ##1 bus_ready_o)
    else $error("margin read ready timing wrong");
  rdata_hv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (arr_rd && hv_on && !prot_rd) |=> bus_rdata_o == SETTLED_BYTE) else $error("array readable under hv");
  erase_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (arr_wr && erase_sel && !hv_on && seq_reg == SEQ_PROTECT_READ)
    |=> erase_addr_o == ($past(bus_addr_i) & erase_mask_o)) else $error("erase address not latched");

endmodule // flash_program_erase_control

// file: bench/flash_array_model.sv
// behavioural array and protect byte standing behind the flash sequencer
`timescale 1ns/10ps
module flash_array_model (
  // lookup
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  prot_i,
  // array data
  output logic [7:0]       rdata_o,
  output logic [7:0]       protect_o
);
  // contents follow the address so a stale or wrong byte shows up
  assign rdata_o   = addr_i[7:0] ^ 8'h3C;
  assign protect_o = prot_i;
endmodule // flash_array_model

// file: bench/tb_flash_program_erase_control.sv
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/10ps
module tb_flash_program_erase_control;
  import flash_ctl_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        bus_sel_i  = 1'b0;
  logic        bus_wr_i   = 1'b0;
  logic [15:0] bus_addr_i = 16'h0000;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic [7:0]  prot_val   = 8'h00;
  logic [7:0]  bus_rdata_o, array_rdata_i, protect_byte_i, page_data_o;
  logic [15:0] page_addr_o, erase_addr_o, erase_mask_o;
  logic        bus_ready_o, array_read_o, page_latch_o, margin_mode_o;
  logic        pump_on_o, high_voltage_o, pump_clk_en_o;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          stall_n;
  logic        rd_seen;
  // bus-cycle stand-in for the program, discharge and verify waits
  localparam int WAIT_CYC = 4;
  logic [7:0]  d;
  always #2.5 core_clk_i = ~core_clk_i;
  flash_program_erase_control dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_sel_i(bus_sel_i),
    .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .bus_ready_o(bus_ready_o), .array_rdata_i(array_rdata_i), .protect_byte_i(protect_byte_i),
    .array_read_o(array_read_o), .page_latch_o(page_latch_o), .page_addr_o(page_addr_o),
    .page_data_o(page_data_o), .erase_addr_o(erase_addr_o), .erase_mask_o(erase_mask_o),
    .margin_mode_o(margin_mode_o), .pump_on_o(pump_on_o), .high_voltage_o(high_voltage_o),
    .pump_clk_en_o(pump_clk_en_o));
  flash_array_model model_u (.addr_i(bus_addr_i), .prot_i(prot_val), .rdata_o(array_rdata_i),
    .protect_o(protect_byte_i));
  // ======================================================================
  // bus tasks
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] v);
    int   n;
    logic r;
    n = 0;
    stall_n = 0;
    @(posedge core_clk_i);
    bus_sel_i   <= 1'b1;
    bus_wr_i    <= w;
    bus_addr_i  <= a;
    bus_wdata_i <= v;
    do
    begin
      @(negedge core_clk_i);
      r = bus_ready_o;
      rd_seen = array_read_o;
      if (r !== 1'b1) stall_n++;
      n++;
      @(posedge core_clk_i);
    end while (r !== 1'b1 && n < 40);
    if (r !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, r, 1'b1);
    end
    bus_sel_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    xfer(1'b0, a, 8'h00);
    v = bus_rdata_o;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ======================================================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    $display("watchdog expired");
    wrap_up;
  end
  // ======================================================================
  // tests
  initial
  begin
    logic [7:0]  c;
    logic [15:0] m;
    int          k;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(CONTROL_ADDR, d); chk(d, 8'h00);
    chk(high_voltage_o, 1'b0);
    rd(16'h0100, d); chk(d, 8'h00);
    rd(16'hA010, d); chk(d, 8'h10 ^ 8'h3C);
    chk(rd_seen, 1'b1);
    $display("reset test done");
    wr(CONTROL_ADDR, 8'h03); rd(CONTROL_ADDR, d); chk(d, 8'h01);
    wr(CONTROL_ADDR, 8'h09); rd(CONTROL_ADDR, d); chk(d, 8'h01);
    chk(high_voltage_o, 1'b0);
    $display("interlock test done");
    // program one page, then margin verify of its first byte
    rd(PROTECT_ADDR, d);
    for (k = 0; k < 8; k++)
    begin
      wr(16'(16'hA008 + k), 8'(8'hA0 + k)); chk(page_latch_o, 1'b1);
      chk({page_addr_o, page_data_o}, {16'(16'hA008 + k), 8'(8'hA0 + k)});
    end
    wr(CONTROL_ADDR, 8'h09);
    chk({pump_on_o, high_voltage_o}, 2'b11);
    repeat (WAIT_CYC) @(posedge core_clk_i);
    wr(CONTROL_ADDR, 8'h0D); rd(CONTROL_ADDR, d); chk(d, 8'h09);
    rd(16'hA008, d); chk({rd_seen, d}, {1'b0, 8'hFF});
    wr(CONTROL_ADDR, 8'h01); chk({pump_on_o, high_voltage_o}, 2'b00);
    repeat (WAIT_CYC) @(posedge core_clk_i);
    wr(CONTROL_ADDR, 8'h05);
    wr(CONTROL_ADDR, 8'h04);
    chk(margin_mode_o, 1'b1);
    rd(16'hA008, d); chk(d, 8'h08 ^ 8'h3C);
    chk(stall_n, MARGIN_STRETCH);
    wr(CONTROL_ADDR, 8'h00);
    rd(16'hA00A, d); chk(stall_n, 0);
    $display("program test done");
    // erase mask per size code, then a row erase with every pump divider
    for (k = 0; k < 4; k++)
    begin
      m = (k == 0) ? 16'h0000 : (k == 1) ? 16'h4000 : (k == 2) ? 16'h7E00 : 16'h7FC0;
      wr(CONTROL_ADDR, 8'(8'h02 | (k << 4))); chk(erase_mask_o, m);
    end
    rd(PROTECT_ADDR, d);
    rd(16'hB000, d);
    wr(16'hA1C5, 8'h5A); chk(erase_addr_o, 16'h21C0);
    wr(CONTROL_ADDR, 8'h3A);
    chk(high_voltage_o, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      wr(CONTROL_ADDR, 8'(8'h3A | (k << 6)));
      m = 0;
      repeat (16)
      begin
        @(negedge core_clk_i);
        m += pump_clk_en_o;
      end
      chk(m, (k == 0) ? 16 : (k == 3) ? 4 : 8);
    end
    wr(CONTROL_ADDR, 8'h32);
    repeat (WAIT_CYC) @(posedge core_clk_i);
    wr(CONTROL_ADDR, 8'h00);
    $display("erase test done");
    // protected ranges drop the select bit and keep high voltage off
    for (k = 0; k < 2; k++)
    begin
      @(posedge core_clk_i);
      prot_val <= (k == 0) ? 8'h08 : 8'h01;
      c = (k == 0) ? 8'h01 : 8'h02;
      m = (k == 0) ? 16'hF000 : 16'hA000;
      wr(CONTROL_ADDR, c);
      rd(PROTECT_ADDR, d);
      repeat ((k == 0) ? 8 : 1)
      begin
        wr(m, 8'h11);
        m++;
      end
      rd(CONTROL_ADDR, d); chk(d, 8'h00);
      wr(CONTROL_ADDR, c | 8'h08); chk(high_voltage_o, 1'b0);
      wr(CONTROL_ADDR, 8'h00);
    end
    $display("protect test done");
    wrap_up;
  end
endmodule // tb_flash_program_erase_control
